// *** rtl/cfs_supervisor.sv ***
// Charger fault and safety supervisor with AXI4-Lite registers
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "cfs_cfg.svh"
module cfs_supervisor #(
  parameter logic [23:0] TICK_CYCLES = `CFS_TICK_CYC,
  parameter logic [15:0] TMR_LIM0 = `CFS_TMR_LIM0,
  parameter logic [15:0] TMR_LIM1 = `CFS_TMR_LIM1,
  parameter logic [15:0] TMR_LIM2 = `CFS_TMR_LIM2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Supply comparators
  input wire logic cmp_uvlo_ok,
  input wire logic cmp_sleep_enter,
  input wire logic cmp_sleep_exit,
  input wire logic cmp_ovp,
  // Die temperature comparators
  input wire logic cmp_treg,
  input wire logic cmp_tshut,
  // Battery temp sense comparators
  input wire logic cmp_ts_below_hot,
  input wire logic cmp_ts_below_warm,
  input wire logic cmp_ts_above_cool,
  input wire logic cmp_ts_above_cold,
  // Set-pin short detectors
  input wire logic cmp_input_limit_set_pin_short,
  input wire logic cmp_charge_current_set_pin_short,
  // Charger loop state
  input wire logic chg_precharge,
  input wire logic chg_terminated,
  // Power stage controls
  output logic buck_enable,
  output logic batfet_enable,
  output logic charge_enable,
  output logic charge_current_reduce,
  output logic input_limit_default_2a,
  output logic [3:0] input_overvoltage_threshold,
  // Status and interrupt
  output logic stat_pulse,
  output logic int_pulse,
  output logic irq
);

  // Synchronised comparators
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic uvlo_ok;
  logic sleep_in;
  logic sleep_out;
  logic ovp;
  logic treg;
  logic tshut;
  logic lt_hot;
  logic lt_warm;
  logic gt_cool;
  logic gt_cold;
  logic input_limit_set_pin_short;
  logic charge_current_set_pin_short;
  logic precharge;
  logic terminated;

  assign raw_in = {cmp_uvlo_ok, cmp_sleep_enter, cmp_sleep_exit, cmp_ovp,
                   cmp_treg, cmp_tshut, cmp_ts_below_hot, cmp_ts_below_warm,
                   cmp_ts_above_cool, cmp_ts_above_cold,
                   cmp_input_limit_set_pin_short,
                   cmp_charge_current_set_pin_short,
                   chg_precharge, chg_terminated};

  cfs_sync #(.W(NSYNC)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(raw_in),
    .sync_out(syn)
  );

  assign {uvlo_ok, sleep_in, sleep_out, ovp, treg, tshut, lt_hot, lt_warm,
          gt_cool, gt_cold, input_limit_set_pin_short, charge_current_set_pin_short, precharge, terminated} = syn;

  // Registers
  logic [31:0] ctrl_q;
  logic [`CFS_EVT_N-1:0] irq_sts_q;
  logic [`CFS_EVT_N-1:0] irq_mask_q;
  logic restart_q;
  logic slow_en;
  logic [1:0] tsel;
  logic chg_en;

  assign slow_en = ctrl_q[`CFS_CTRL_SLOW];
  assign tsel = ctrl_q[`CFS_CTRL_TSEL_HI:`CFS_CTRL_TSEL_LO];
  assign chg_en = ctrl_q[`CFS_CTRL_CHG_EN];

  // Host field clamped to the top legal step
  logic [3:0] ovp_field;
  assign ovp_field = ctrl_q[`CFS_CTRL_OVP_HI:`CFS_CTRL_OVP_LO];
  assign input_overvoltage_threshold =
    (ovp_field > `CFS_OVP_MAX) ? `CFS_OVP_MAX : ovp_field;

  // Temperature zone
  cfs_pkg::cfs_zone_e zone_d;
  cfs_pkg::cfs_zone_e zone_q;

  always_comb begin
    if (lt_hot) begin
      zone_d = cfs_pkg::TZ_HOT;
    end else if (lt_warm) begin
      zone_d = cfs_pkg::TZ_WARM;
    end else if (gt_cold) begin
      zone_d = cfs_pkg::TZ_COLD;
    end else if (gt_cool) begin
      zone_d = cfs_pkg::TZ_COOL;
    end else begin
      zone_d = cfs_pkg::TZ_NORMAL;
    end
  end

  logic ts_fault;
  logic ts_reduce;
  assign ts_fault = (zone_d == cfs_pkg::TZ_HOT) || (zone_d == cfs_pkg::TZ_COLD);
  assign ts_reduce = (zone_d == cfs_pkg::TZ_COOL);

  // Sleep state, with lockout taking precedence
  logic sleep_q;
  logic sleep_d;
  logic uvlo_q;

  always_comb begin
    sleep_d = sleep_q;
    if (!uvlo_ok) begin
      sleep_d = 1'b0;
    end else if (sleep_q && sleep_out) begin
      sleep_d = 1'b0;
    end else if (!sleep_q && sleep_in) begin
      sleep_d = 1'b1;
    end
  end

  logic sleep_exit;
  logic uvlo_rise;
  logic cycle_start;
  assign sleep_exit = sleep_q && !sleep_d && uvlo_ok;
  assign uvlo_rise = uvlo_ok && !uvlo_q;
  // Fresh charge cycle resets the timer and clears a timer fault
  assign cycle_start = sleep_exit || uvlo_rise || restart_q;

  // Safety timer
  logic [23:0] tick_q;
  logic half_q;
  logic [15:0] sec_q;
  logic tmr_exp_q;
  logic tmr_pause;
  logic tmr_run;
  logic tmr_slow;
  logic tick;
  logic advance;
  logic expire;
  logic [15:0] tmr_lim;

  assign tmr_lim = (tsel == 2'h0) ? TMR_LIM0 :
                   (tsel == 2'h1) ? TMR_LIM1 : TMR_LIM2;
  assign tmr_pause = ovp || ts_fault || tshut || sleep_q || charge_current_set_pin_short;
  assign tmr_run = uvlo_ok && chg_en && !terminated && !tmr_exp_q && !tmr_pause
                   && (tsel != `CFS_TSEL_OFF);
  assign tmr_slow = slow_en && (precharge || treg || ts_reduce);
  assign tick = tmr_run && (tick_q == TICK_CYCLES - 24'h00_0001);
  assign advance = tick && (!tmr_slow || half_q);
  assign expire = advance && (sec_q + 16'h0001 >= tmr_lim);

  // Sub-tick count is held while paused so no time is lost
  always_ff @(posedge aclk) begin
    if (!aresetn || cycle_start) begin
      tick_q <= 24'h00_0000;
    end else if (tick) begin
      tick_q <= 24'h00_0000;
    end else if (tmr_run) begin
      tick_q <= tick_q + 24'h00_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cycle_start) begin
      half_q <= 1'b0;
    end else if (tick && tmr_slow) begin
      half_q <= !half_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cycle_start) begin
      sec_q <= 16'h0000;
    end else if (expire) begin
      sec_q <= 16'h0000;
    end else if (advance) begin
      sec_q <= sec_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cycle_start) begin
      tmr_exp_q <= 1'b0;
    end else if (expire) begin
      tmr_exp_q <= 1'b1;
    end
  end

  // Power stage decisions
  logic buck_d;
  logic chg_d;
  // Next sleep state, so the converter never blips on at sleep entry
  assign buck_d = uvlo_ok && !sleep_d && !ovp && !tshut;
  // Warm zone is absent here on purpose
  assign chg_d = buck_d && chg_en && !ts_fault && !charge_current_set_pin_short
                 && !tmr_exp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buck_enable <= 1'b0;
      batfet_enable <= 1'b0;
      charge_enable <= 1'b0;
      charge_current_reduce <= 1'b0;
      input_limit_default_2a <= 1'b0;
    end else begin
      buck_enable <= buck_d;
      batfet_enable <= sleep_q || !buck_d;
      charge_enable <= chg_d;
      charge_current_reduce <= ts_reduce;
      input_limit_default_2a <= input_limit_set_pin_short;
    end
  end

  // Event detection on synchronised levels
  logic ovp_q;
  logic tshut_q;
  logic charge_current_set_pin_q;
  logic tsf_q;
  logic [`CFS_EVT_N-1:0] evt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_q <= 1'b0;
      uvlo_q <= 1'b0;
      ovp_q <= 1'b0;
      tshut_q <= 1'b0;
      charge_current_set_pin_q <= 1'b0;
      tsf_q <= 1'b0;
      zone_q <= cfs_pkg::TZ_NORMAL;
    end else begin
      sleep_q <= sleep_d;
      uvlo_q <= uvlo_ok;
      ovp_q <= ovp;
      tshut_q <= tshut;
      charge_current_set_pin_q <= charge_current_set_pin_short;
      tsf_q <= ts_fault;
      zone_q <= zone_d;
    end
  end

  assign evt = {charge_current_set_pin_short && !charge_current_set_pin_q,
                ts_fault && !tsf_q,
                (zone_d == cfs_pkg::TZ_WARM) && (zone_q != cfs_pkg::TZ_WARM),
                expire,
                tshut && !tshut_q,
                ovp && !ovp_q,
                sleep_d && !sleep_q};

  // One shared pulse drives both open-drain status pins
  logic pulse;
  cfs_pulse u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .trigger(|evt),
    .pulse(pulse)
  );

  assign stat_pulse = pulse;
  assign int_pulse = pulse;

  // AXI4-Lite slave
  function automatic logic [1:0] reg_index(input logic [7:0] addr);
    if (addr == `CFS_ADDR_CTRL) begin
      reg_index = 2'h0;
    end else if (addr == `CFS_ADDR_STATUS) begin
      reg_index = 2'h1;
    end else if (addr == `CFS_ADDR_IRQ_STS) begin
      reg_index = 2'h2;
    end else begin
      reg_index = 2'h3;
    end
  endfunction : reg_index

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr == `CFS_ADDR_CTRL) || (addr == `CFS_ADDR_STATUS) ||
                 (addr == `CFS_ADDR_IRQ_STS) || (addr == `CFS_ADDR_IRQ_MASK);
  endfunction : reg_mapped

  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] bytemask;
  logic [31:0] wbits;
  logic wr_ctrl;
  logic wr_sts;
  logic wr_mask;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign wr_fire = s_awvalid && s_wvalid && !bvalid_q;
  assign s_awready = wr_fire;
  assign s_wready = wr_fire;
  assign rd_fire = s_arvalid && !rvalid_q;
  assign s_arready = !rvalid_q;
  assign bytemask = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
  assign wbits = s_wdata & bytemask;
  assign wr_ctrl = wr_fire && reg_mapped(s_awaddr) && (reg_index(s_awaddr) == 2'h0);
  assign wr_sts = wr_fire && reg_mapped(s_awaddr) && (reg_index(s_awaddr) == 2'h2);
  assign wr_mask = wr_fire && reg_mapped(s_awaddr) && (reg_index(s_awaddr) == 2'h3);

  // Live state; fault bits other than the latched timer expiry fall back on their own once the cause clears
  assign status_word = {19'h0_0000, zone_q, tmr_exp_q, charge_current_set_pin_short, input_limit_set_pin_short,
                        tshut, ovp, sleep_q, charge_enable, buck_enable};

  always_comb begin
    if (!reg_mapped(s_araddr)) begin
      rd_word = 32'h0000_0000;
    end else if (reg_index(s_araddr) == 2'h0) begin
      rd_word = ctrl_q;
    end else if (reg_index(s_araddr) == 2'h1) begin
      rd_word = status_word;
    end else if (reg_index(s_araddr) == 2'h2) begin
      rd_word = {25'h000_0000, irq_sts_q};
    end else begin
      rd_word = {25'h000_0000, irq_mask_q};
    end
  end

  // Restart bit is a strobe and never reads back as one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CFS_CTRL_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_ctrl && wbits[`CFS_CTRL_RESTART];
      if (wr_ctrl) begin
        ctrl_q <= (ctrl_q & ~(bytemask & `CFS_CTRL_WMASK)) |
                  (wbits & `CFS_CTRL_WMASK);
      end
    end
  end

  // Event set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_q <= 7'h00;
      irq_mask_q <= 7'h00;
      irq <= 1'b0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~(wr_sts ? wbits[`CFS_EVT_N-1:0] : 7'h00)) | evt;
      if (wr_mask) begin
        irq_mask_q <= wbits[`CFS_EVT_N-1:0];
      end
      irq <= |(irq_sts_q & irq_mask_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CFS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= reg_mapped(s_awaddr) ? `CFS_RESP_OKAY : `CFS_RESP_SLVERR;
    end else if (s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= `CFS_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= reg_mapped(s_araddr) ? `CFS_RESP_OKAY : `CFS_RESP_SLVERR;
      rdata_q <= rd_word;
    end else if (s_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_rvalid = rvalid_q;
  assign s_rresp = rresp_q;
  assign s_rdata = rdata_q;

endmodule : cfs_supervisor

// *** rtl/cfs_cfg.svh ***
// Constants of the charger fault and safety supervisor
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH

// Register byte offsets
`define CFS_ADDR_CTRL 8'h00
`define CFS_ADDR_STATUS 8'h04
`define CFS_ADDR_IRQ_STS 8'h08
`define CFS_ADDR_IRQ_MASK 8'h0c

// Control fields and reset value
`define CFS_CTRL_SLOW 0
`define CFS_CTRL_TSEL_LO 1
`define CFS_CTRL_TSEL_HI 2
`define CFS_CTRL_OVP_LO 4
`define CFS_CTRL_OVP_HI 7
`define CFS_CTRL_RESTART 8
`define CFS_CTRL_CHG_EN 9
`define CFS_CTRL_RST 32'h0000_0200
`define CFS_CTRL_WMASK 32'h0000_02f7

// Overvoltage select: 6.5V plus 0.5V a step, top code 10.5V
`define CFS_OVP_MAX 4'h8
`define CFS_TSEL_OFF 2'h3

// Number of event bits in the interrupt status
`define CFS_EVT_N 7

// Pulse width: time in microseconds, clock in MHz
`define CFS_PULSE_US 12'h100
`define CFS_CLK_MHZ 12'h00a
`define CFS_PULSE_CYC (`CFS_PULSE_US * `CFS_CLK_MHZ)

// Timer base: one tick a second at 10 MHz, limits in ticks
`define CFS_TICK_CYC 24'h98_9680
`define CFS_TMR_LIM0 16'h0a8c
`define CFS_TMR_LIM1 16'h5460
`define CFS_TMR_LIM2 16'h7e90

// Comparator trip points in tenths of a percent of reference
`define CFS_TS_HOT_PM 12'h12c
`define CFS_TS_WARM_PM 12'h17f
`define CFS_TS_COOL_PM 12'h1e5
`define CFS_TS_COLD_PM 12'h258

// AXI responses
`define CFS_RESP_OKAY 2'h0
`define CFS_RESP_SLVERR 2'h2

`endif

// *** rtl/cfs_pkg.sv ***
// Types of the charger fault and safety supervisor
package cfs_pkg;

  // Battery temperature zone, one-hot
  typedef enum logic [4:0] {
    TZ_COLD = 5'h01,
    TZ_COOL = 5'h02,
    TZ_NORMAL = 5'h04,
    TZ_WARM = 5'h08,
    TZ_HOT = 5'h10
  } cfs_zone_e;

endpackage : cfs_pkg

// *** rtl/cfs_sync.sv ***
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module cfs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_out = sync_q;

endmodule : cfs_sync

// *** rtl/cfs_pulse.sv ***
// Fixed-width status pulse generator
`timescale 1ns/1ps
`include "cfs_cfg.svh"
module cfs_pulse (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Trigger and pulse
  input wire logic trigger,
  output logic pulse
);

  logic [11:0] cnt_q;
  logic busy_q;
  logic [11:0] last_cyc;

  assign last_cyc = 12'(`CFS_PULSE_CYC - 1);

  // Triggers inside a pulse are merged, never restarting it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 12'h000;
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 12'h001;
      if (cnt_q == last_cyc) begin
        busy_q <= 1'b0;
      end
    end else if (trigger) begin
      cnt_q <= 12'h000;
      busy_q <= 1'b1;
    end
  end

  assign pulse = busy_q;

endmodule : cfs_pulse

// *** bench/cfs_sup_chk.sv ***
// Port assertions for the charger supervisor
`timescale 1ns/1ps
module cfs_sup_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Comparator inputs
  input wire logic cmp_uvlo_ok,
  input wire logic cmp_sleep_enter,
  input wire logic cmp_sleep_exit,
  input wire logic cmp_ovp,
  input wire logic cmp_tshut,
  input wire logic cmp_input_limit_set_pin_short,
  input wire logic cmp_charge_current_set_pin_short,
  // Power stage and pins
  input wire logic buck_enable,
  input wire logic batfet_enable,
  input wire logic charge_enable,
  input wire logic input_limit_default_2a,
  input wire logic [3:0] input_overvoltage_threshold,
  input wire logic stat_pulse,
  input wire logic int_pulse
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Length of the pulse so far; too wide for a repetition count
  logic [11:0] run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !stat_pulse) begin
      run_q <= 12'h000;
    end else begin
      run_q <= run_q + 12'h001;
    end
  end

  a_pulse_pins_equal: assert property (stat_pulse == int_pulse)
    else $error("status and interrupt pulses differ");
  a_pulse_never_long: assert property (run_q <= 12'ha00)
    else $error("pulse wider than 2560 cycles");
  a_pulse_exact_width: assert property ($fell(stat_pulse) |-> run_q == 12'ha00)
    else $error("pulse ended early");
  // Four samples: two synchroniser stages, one output register
  a_ovp_stops_buck: assert property (cmp_ovp [*4] |-> !buck_enable && !charge_enable)
    else $error("overvoltage left the converter on");
  a_tshut_stops_all: assert property (cmp_tshut [*4] |-> !buck_enable && !charge_enable)
    else $error("thermal shutdown left the converter on");
  a_sleep_batfet_on: assert property (
    (cmp_sleep_enter && cmp_uvlo_ok && !cmp_sleep_exit) [*4] |-> batfet_enable && !buck_enable)
    else $error("sleep did not swap converter for battery switch");
  a_no_uvlo_no_chg: assert property (!cmp_uvlo_ok [*4] |-> !charge_enable)
    else $error("charging below lockout");
  a_charge_current_set_pin_short_halt: assert property (
    cmp_charge_current_set_pin_short [*4] |-> !charge_enable)
    else $error("charging with current pin shorted");
  a_input_limit_set_pin_short_dflt: assert property (
    cmp_input_limit_set_pin_short [*4] |-> input_limit_default_2a)
    else $error("input limit default not taken");
  a_ovp_code_range: assert property (input_overvoltage_threshold <= 4'h8)
    else $error("overvoltage code beyond top step");
endmodule : cfs_sup_chk

bind cfs_supervisor cfs_sup_chk chk_u (
  .aclk, .aresetn, .cmp_uvlo_ok, .cmp_sleep_enter, .cmp_sleep_exit, .cmp_ovp, .cmp_tshut,
  .cmp_input_limit_set_pin_short, .cmp_charge_current_set_pin_short, .buck_enable,
  .batfet_enable, .charge_enable, .input_limit_default_2a, .input_overvoltage_threshold,
  .stat_pulse, .int_pulse
);

// *** bench/cfs_host_model.sv ***
// Host model that counts and times the status pulses
`timescale 1ns/1ps
module cfs_host_model (
  // Clock
  input wire logic aclk,
  // Pulse pins, high while pulled low
  input wire logic stat_pulse,
  input wire logic int_pulse,
  // Observations
  output int pulses,
  output int width,
  output int mism
);
  int run;
  always @(posedge aclk) begin
    if (stat_pulse !== int_pulse) begin
      mism <= mism + 1;
    end
    if (stat_pulse === 1'b1) begin
      if (run == 0) begin
        pulses <= pulses + 1;
      end
      run <= run + 1;
    end else begin
      if (run != 0) begin
        width <= run;
      end
      run <= 0;
    end
  end
endmodule : cfs_host_model

// *** bench/tb.sv ***
// Self-checking bench of the charger supervisor
`timescale 1ns/1ps
`include "cfs_cfg.svh"
module tb;
  localparam logic [7:0] ctl = `CFS_ADDR_CTRL;
  localparam logic [7:0] sta = `CFS_ADDR_STATUS;
  localparam logic [7:0] sts = `CFS_ADDR_IRQ_STS;
  localparam logic [7:0] msk = `CFS_ADDR_IRQ_MASK;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0000_0000;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  // Uvlo, enter, exit, ovp, treg, tshut, four temp, input_limit_set_pin, charge_current_set_pin, precharge, done
  logic [13:0] pin = 14'h0005;
  logic [31:0] s_rdata;
  logic [1:0] s_bresp, s_rresp;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic buck_enable, batfet_enable, charge_enable, charge_current_reduce;
  logic input_limit_default_2a, stat_pulse, int_pulse, irq;
  logic [3:0] input_overvoltage_threshold;
  logic [3:0] tp [4] = '{4'h2, 4'h3, 4'h4, 4'hc};
  logic [15:0] te [4] = '{16'h0803, 16'h1001, 16'h0203, 16'h0101};
  logic [3:0] oc [3] = '{4'hf, 4'h8, 4'h3};
  int bad_count, checks_done, pulses, width, mism, base;

  always #50 aclk = ~aclk;

  // Short tick and limits keep the timer runs brief
  cfs_supervisor #(.TICK_CYCLES(24'h00_0004), .TMR_LIM0(16'h0003), .TMR_LIM1(16'h0005),
    .TMR_LIM2(16'h0007)) dut_u (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .cmp_uvlo_ok(pin[0]), .cmp_sleep_enter(pin[1]),
    .cmp_sleep_exit(pin[2]), .cmp_ovp(pin[3]), .cmp_treg(pin[4]), .cmp_tshut(pin[5]),
    .cmp_ts_below_hot(pin[6]), .cmp_ts_below_warm(pin[7]), .cmp_ts_above_cool(pin[8]),
    .cmp_ts_above_cold(pin[9]), .cmp_input_limit_set_pin_short(pin[10]),
    .cmp_charge_current_set_pin_short(pin[11]), .chg_precharge(pin[12]),
    .chg_terminated(pin[13]), .buck_enable, .batfet_enable, .charge_enable,
    .charge_current_reduce, .input_limit_default_2a, .input_overvoltage_threshold,
    .stat_pulse, .int_pulse, .irq);

  cfs_host_model host_u (.aclk, .stat_pulse, .int_pulse, .pulses, .width, .mism);

  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // Ready and valid are read at the falling edge, so they are settled
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do @(negedge aclk); while (s_awready !== 1'b1 || s_wready !== 1'b1);
    @(posedge aclk);
    s_awvalid <= 1'b0;
    s_wvalid <= 1'b0;
    do @(negedge aclk); while (s_bvalid !== 1'b1);
    chk("bresp", e, s_bresp);
    @(posedge aclk);
    s_bready <= 1'b0;
  endtask : wr

  task automatic rc(string w, logic [7:0] a, logic [31:0] m, logic [31:0] e, logic [1:0] r);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(negedge aclk); while (s_arready !== 1'b1);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    do @(negedge aclk); while (s_rvalid !== 1'b1);
    chk(w, e, s_rdata & m);
    chk("rresp", r, s_rresp);
    @(posedge aclk);
    s_rready <= 1'b0;
  endtask : rc

  task automatic cyc(int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : cyc

  task automatic pset(int i, logic v);
    @(posedge aclk);
    pin[i] <= v;
    cyc(5);
  endtask : pset

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl", ctl, 32'hffff_ffff, 32'h0000_0200, 2'h0);
    rc("mask", msk, 32'hffff_ffff, 32'h0000_0000, 2'h0);
    rc("hole", 8'h10, 32'hffff_ffff, 32'h0000_0000, 2'h2);
    wr(8'h10, 32'h0000_0001, 2'h2);
    wr(ctl, 32'h0000_0336, 2'h0);
    rc("ctrl rb", ctl, 32'hffff_ffff, 32'h0000_0236, 2'h0);
    cyc(2600);
    wr(msk, 32'h0000_007f, 2'h0);
    wr(sts, 32'h0000_007f, 2'h0);
    rc("status", sta, 32'h0000_1fff, 32'h0000_0403, 2'h0);
    $display("test reset finished");
    for (int i = 0; i < 3; i++) begin
      wr(ctl, {22'h0, 2'h2, oc[i], 4'h6}, 2'h0);
      cyc(1);
      chk("ovp code", (oc[i] > 4'h8) ? 4'h8 : oc[i], input_overvoltage_threshold);
    end
    base = pulses;
    pset(3, 1'b1);
    chk("buck", 1'b0, buck_enable);
    chk("chg", 1'b0, charge_enable);
    chk("pulse", 1'b1, stat_pulse);
    // Shutdown inside the pulse must not stretch it
    pset(5, 1'b1);
    pset(5, 1'b0);
    rc("ovp sts", sts, 32'h0000_0006, 32'h0000_0006, 2'h0);
    rc("ovp stat", sta, 32'h0000_001b, 32'h0000_0008, 2'h0);
    chk("irq", 1'b1, irq);
    pset(3, 1'b0);
    chk("chg", 1'b1, charge_enable);
    rc("ovp gone", sta, 32'h0000_000b, 32'h0000_0003, 2'h0);
    cyc(2600);
    chk("pulses", base + 1, pulses);
    chk("width", 32'h0000_0a00, width);
    wr(sts, 32'h0000_007f, 2'h0);
    cyc(2);
    chk("irq", 1'b0, irq);
    $display("test overvoltage finished");
    wr(msk, 32'h0000_003f, 2'h0);
    pset(11, 1'b1);
    chk("chg", 1'b0, charge_enable);
    chk("masked irq", 1'b0, irq);
    wr(msk, 32'h0000_007f, 2'h0);
    cyc(2);
    chk("irq", 1'b1, irq);
    pset(11, 1'b0);
    pset(10, 1'b1);
    chk("input_limit_set_pin", 1'b1, input_limit_default_2a);
    rc("shorts", sta, 32'h0000_0062, 32'h0000_0022, 2'h0);
    pset(10, 1'b0);
    wr(sts, 32'h0000_007f, 2'h0);
    cyc(2600);
    $display("test set pins finished");
    base = pulses;
    pset(0, 1'b0);
    pset(2, 1'b0);
    pset(1, 1'b1);
    rc("no sleep", sta, 32'h0000_0004, 32'h0000_0000, 2'h0);
    pset(0, 1'b1);
    chk("batfet", 1'b1, batfet_enable);
    chk("buck", 1'b0, buck_enable);
    rc("sleep", sta, 32'h0000_0007, 32'h0000_0004, 2'h0);
    rc("sleep sts", sts, 32'h0000_0001, 32'h0000_0001, 2'h0);
    chk("pulses", base + 1, pulses);
    pset(1, 1'b0);
    pset(2, 1'b1);
    rc("wake", sta, 32'h0000_0007, 32'h0000_0003, 2'h0);
    cyc(2600);
    $display("test sleep finished");
    wr(sts, 32'h0000_007f, 2'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      pin[9:6] <= tp[i];
      cyc(5);
      chk("reduce", i == 2, charge_current_reduce);
      rc("zone", sta, 32'h0000_1f03, te[i], 2'h0);
    end
    rc("ts sts", sts, 32'h0000_0030, 32'h0000_0030, 2'h0);
    @(posedge aclk);
    pin[9:6] <= 4'h0;
    cyc(2600);
    $display("test temperature finished");
    base = pulses;
    wr(ctl, 32'h0000_0330, 2'h0);
    cyc(5);
    chk("chg run", 1'b1, charge_enable);
    cyc(15);
    chk("chg expired", 1'b0, charge_enable);
    rc("expired", sta, 32'h0000_0082, 32'h0000_0080, 2'h0);
    rc("tmr sts", sts, 32'h0000_0008, 32'h0000_0008, 2'h0);
    chk("pulses", base + 1, pulses);
    pset(12, 1'b1);
    wr(ctl, 32'h0000_0333, 2'h0);
    cyc(30);
    chk("slow run", 1'b1, charge_enable);
    cyc(30);
    chk("slow end", 1'b0, charge_enable);
    pset(12, 1'b0);
    wr(ctl, 32'h0000_0334, 2'h0);
    cyc(4);
    pset(3, 1'b1);
    cyc(60);
    pset(3, 1'b0);
    chk("paused", 1'b1, charge_enable);
    cyc(30);
    chk("resumed", 1'b0, charge_enable);
    wr(ctl, 32'h0000_0336, 2'h0);
    cyc(100);
    chk("timer off", 1'b1, charge_enable);
    cyc(2600);
    $display("test timer finished");
    base = pulses;
    pset(5, 1'b1);
    chk("tshut buck", 1'b0, buck_enable);
    chk("pulses", base + 1, pulses);
    pset(5, 1'b0);
    chk("pin pair", 0, mism);
    $display("test shutdown finished");
    wrap_up();
  end

  // Tests need about 16000 cycles
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    wrap_up();
  end
endmodule : tb
